/* rtl/imr_cfg.svh */
/*
  constants of the mode, rate and bit-count block: register offsets, field
  positions, reset values, divider ratios and frame length codes.
  assumes it is included by bare name from files of the imr block.
*/
`ifndef IMR_CFG_SVH
`define IMR_CFG_SVH

// ======================================================================
// register byte offsets
`define IMR_ADDR_MODE 8'h00
`define IMR_ADDR_CTRL 8'h04
`define IMR_ADDR_STAT 8'h08
`define IMR_ADDR_LSB 0
`define IMR_ADDR_MSB 7
`define IMR_HTRANS_ACT 1

// ======================================================================
// transfer mode register fields
`define IMR_MODE_RST 8'h00
`define IMR_MODE_ORDER 7
`define IMR_MODE_WAIT 6
`define IMR_MODE_CKS_HI 5
`define IMR_MODE_CKS_LO 3
`define IMR_MODE_BC_HI 2
`define IMR_MODE_BC_LO 0

// ======================================================================
// control and status register fields
`define IMR_CTRL_EN 0
`define IMR_CTRL_MST 1
`define IMR_CTRL_SYNC 2
`define IMR_CTRL_RANGE 3
`define IMR_CTRL_GO 4
`define IMR_STAT_IRQ 0
`define IMR_STAT_BUSY 1
`define IMR_STAT_WAIT 2
`define IMR_STAT_LEFT_HI 7
`define IMR_STAT_LEFT_LO 4

// ======================================================================
// full transfer clock periods in peripheral clock cycles, range 0
`define IMR_RATIO_N0 9'h01c
`define IMR_RATIO_N1 9'h028
`define IMR_RATIO_N2 9'h030
`define IMR_RATIO_N3 9'h040
`define IMR_RATIO_N4 9'h050
`define IMR_RATIO_N5 9'h064
`define IMR_RATIO_N6 9'h070
`define IMR_RATIO_N7 9'h080
// full periods, range 1
`define IMR_RATIO_W0 9'h038
`define IMR_RATIO_W1 9'h050
`define IMR_RATIO_W2 9'h060
`define IMR_RATIO_W3 9'h080
`define IMR_RATIO_W4 9'h0a0
`define IMR_RATIO_W5 9'h0c8
`define IMR_RATIO_W6 9'h0e0
`define IMR_RATIO_W7 9'h100

// ======================================================================
// frame length coding
`define IMR_BC_ZERO 3'h0
`define IMR_LEN_I2C_ZERO 4'h9
`define IMR_LEN_SYNC_ZERO 4'h8
`define IMR_LEN_I2C_OFS 4'h1
`define IMR_LEFT_ACK 4'h1

`endif

/* rtl/imr_pkg.sv */
/*
  types of the mode, rate and bit-count block: the packed state of each
  module. assumes imr_cfg.svh holds the numbers.
*/
package imr_pkg;

  // ======================================================================
  // divider state
  typedef struct packed {
    logic [7:0] cnt;  // cycles spent in the current half period
    logic tick;       // one-cycle pulse at each half period end
  } imr_div_st_t;

  // ======================================================================
  // bit counter state
  typedef struct packed {
    logic [3:0] left; // bits still to shift in the frame
    logic done;       // pulse: last bit of the frame shifted
    logic last;       // pulse: only the acknowledge bit remains
  } imr_cnt_st_t;

  // ======================================================================
  // top level state
  typedef struct packed {
    logic rd_pend;       // read data phase pending
    logic wr_pend;       // write data phase pending
    logic [7:0] addr;    // latched address of the data phase
    logic hready;        // ready toward the bus
    logic hresp;         // response, always okay
    logic [31:0] hrdata; // read data
    logic [7:0] mode;    // transfer mode register
    logic en;            // interface enable
    logic mst;           // master operation
    logic sync_fmt;      // synchronous serial format
    logic range;         // divider range select
    logic irq;           // transfer interrupt flag
    logic busy;          // frame in progress
    logic wait_st;       // waiting before acknowledge
    logic scl_lo;        // driving the serial clock low
    logic scl_o;         // serial clock output value
    logic sda_p;         // previous data line sample
    logic scl_p;         // previous clock line sample
  } imr_top_st_t;

endpackage

/* rtl/imr_clk_div.sv */
/*
  transfer clock divider: emits a pulse at every half period of the
  selected division ratio.
  assumes en is a registered level and the select is stable while en is high.
*/
`timescale 1ns/100ps
`include "imr_cfg.svh"

module imr_clk_div (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic en,
  input wire logic range,
  input wire logic [2:0] sel,
  // half period pulse
  output logic tick
);

  // ======================================================================
  // ratio table
  // full period for a select code and range
  function automatic logic [8:0] ratio_of(input logic rng, input logic [2:0] s);
    logic [8:0] r;
    r = `IMR_RATIO_N0;
    unique case ({rng, s})
      4'h0: r = `IMR_RATIO_N0;
      4'h1: r = `IMR_RATIO_N1;
      4'h2: r = `IMR_RATIO_N2;
      4'h3: r = `IMR_RATIO_N3;
      4'h4: r = `IMR_RATIO_N4;
      4'h5: r = `IMR_RATIO_N5;
      4'h6: r = `IMR_RATIO_N6;
      4'h7: r = `IMR_RATIO_N7;
      4'h8: r = `IMR_RATIO_W0;
      4'h9: r = `IMR_RATIO_W1;
      4'ha: r = `IMR_RATIO_W2;
      4'hb: r = `IMR_RATIO_W3;
      4'hc: r = `IMR_RATIO_W4;
      4'hd: r = `IMR_RATIO_W5;
      4'he: r = `IMR_RATIO_W6;
      4'hf: r = `IMR_RATIO_W7;
    endcase
    return r;
  endfunction

  imr_pkg::imr_div_st_t st_q;
  imr_pkg::imr_div_st_t st_d;
  logic [7:0] term; // last count of a half period
  logic [8:0] full; // full period of the selected ratio

  // ======================================================================
  // next state: two half periods make one full ratio
  always_comb begin
    st_d = st_q;
    full = ratio_of(range, sel);
    term = full[8:1] - 8'h01;
    st_d.tick = 1'b0;
    if (!en) begin
      st_d.cnt = 8'h00; // idle divider restarts from zero
    end else if (st_q.cnt == term) begin
      st_d.cnt = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule // imr_clk_div

/* rtl/imr_bit_cnt.sv */
/*
  frame bit counter: loads a frame length, counts shifted bits down and
  pulses when only the acknowledge bit remains and when the frame ends.
  assumes step is a one-cycle pulse per serial clock fall.
*/
`timescale 1ns/100ps
`include "imr_cfg.svh"

module imr_bit_cnt (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic clr,
  input wire logic load,
  input wire logic [3:0] len,
  input wire logic step,
  // state
  output logic [3:0] left,
  output logic done,
  output logic last
);

  imr_pkg::imr_cnt_st_t st_q;
  imr_pkg::imr_cnt_st_t st_d;

  // ======================================================================
  // next state: load wins over clear so an enabling start is kept
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.last = 1'b0;
    if (load) begin
      st_d.left = len;
    end else if (clr) begin
      st_d.left = 4'h0;
    end else if (step && st_q.left != 4'h0) begin
      st_d.left = st_q.left - 4'h1;
      st_d.done = (st_q.left == `IMR_LEFT_ACK);
      st_d.last = (st_q.left == `IMR_LEFT_ACK + 4'h1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign left = st_q.left;
  assign done = st_q.done;
  assign last = st_q.last;

endmodule // imr_bit_cnt

/* rtl/imr_mode_rate_bitcount.sv */
/*
  mode, rate and bit-count part of a two-wire serial interface, with an
  ahb-lite register slave, serial clock generation and frame counting.
  assumes serial line inputs are synchronous to clk and the shifter outside
  uses bit_order_lsb.
*/
// The register offsets and the AHB-Lite register port were chosen for this implementation.
//
// Behaviour
// - mode register usable only while interface enabled
// - bit 7 selects lsb or msb first
// - ack wait only for two-wire master
// - wait off: data and ack back to back
// - clearing flag releases clock for ack
// - range 0 ratios 28 to 128
// - range 1 ratios 56 to 256
// - divided clock drives line only as master
// - two-wire frames: 000 is 9, else 2-8
// - sync frames: 000 is 8, else 1-7
// - start condition forces bit counter to zero
// - counter returns to zero after frame
// - disabling clears internal transfer state
// - short frames aligned per bit order select
`timescale 1ns/100ps
`include "imr_cfg.svh"

module imr_mode_rate_bitcount (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  // toward the shifter
  output logic bit_order_lsb
);

  // ======================================================================
  // decoding helpers
  // frame length for a bit-count code and format
  function automatic logic [3:0] frame_len(input logic sync, input logic [2:0] code);
    logic [3:0] l;
    l = {1'b0, code};
    if (code == `IMR_BC_ZERO) begin
      l = sync ? `IMR_LEN_SYNC_ZERO : `IMR_LEN_I2C_ZERO;
    end else if (!sync) begin
      l = {1'b0, code} + `IMR_LEN_I2C_OFS;
    end
    return l;
  endfunction

  // register targets of reads and writes, one decoder for all
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ======================================================================
  // state and nets
  imr_pkg::imr_top_st_t st_q; // all registered state
  imr_pkg::imr_top_st_t st_d; // next state

  // bus side
  logic acc;                  // address phase taken this cycle

  // divider and counter
  logic div_en;               // divider running
  logic div_tick;             // half period pulse
  logic cnt_load;             // load frame length
  logic cnt_clr;              // clear counter
  logic cnt_step;             // one bit shifted
  logic [3:0] cnt_left;       // bits still to shift
  logic cnt_done;             // frame finished pulse
  logic cnt_last;             // only acknowledge remains pulse
  logic [3:0] len_sel;        // length of the next frame

  // line and flag events
  logic start_det;            // start condition seen on the bus
  logic scl_fall;             // falling serial clock seen
  logic wait_eff;             // acknowledge wait active in this mode
  logic irq_set;              // flag set event
  logic irq_clr;              // flag cleared by software

  // read path
  logic [31:0] rd_val;        // read value of the latched address
  logic [7:0] stat_val;       // status byte

  // ======================================================================
  // submodules
  // divider runs only for a master frame that is not waiting
  assign div_en = st_q.en & st_q.mst & st_q.busy & ~st_q.wait_st;

  imr_clk_div u_div (
    .clk(clk),
    .rstn(rstn),
    .en(div_en),
    .range(st_q.range),
    .sel(st_q.mode[`IMR_MODE_CKS_HI:`IMR_MODE_CKS_LO]),
    .tick(div_tick)
  );

  // frame counter, load wins over the disable clear
  imr_bit_cnt u_cnt (
    .clk(clk),
    .rstn(rstn),
    .clr(cnt_clr),
    .load(cnt_load),
    .len(len_sel),
    .step(cnt_step),
    .left(cnt_left),
    .done(cnt_done),
    .last(cnt_last)
  );

  // ======================================================================
  // read mux
  // status byte and register read values
  always_comb begin
    stat_val = 8'h00;
    stat_val[`IMR_STAT_IRQ] = st_q.irq;
    stat_val[`IMR_STAT_BUSY] = st_q.busy;
    stat_val[`IMR_STAT_WAIT] = st_q.wait_st;
    stat_val[`IMR_STAT_LEFT_HI:`IMR_STAT_LEFT_LO] = cnt_left;

    // unmapped offsets read zero
    rd_val = 32'h0000_0000;
    if (hit(st_q.addr, `IMR_ADDR_MODE)) begin
      // mode register reads zero while disabled
      rd_val[7:0] = st_q.en ? st_q.mode : 8'h00;
    end else if (hit(st_q.addr, `IMR_ADDR_CTRL)) begin
      rd_val[`IMR_CTRL_EN] = st_q.en;
      rd_val[`IMR_CTRL_MST] = st_q.mst;
      rd_val[`IMR_CTRL_SYNC] = st_q.sync_fmt;
      rd_val[`IMR_CTRL_RANGE] = st_q.range;
    end else if (hit(st_q.addr, `IMR_ADDR_STAT)) begin
      rd_val[7:0] = stat_val;
    end
  end

  // ======================================================================
  // bus line observation
  // start: data falls while clock stays high
  assign start_det = scl_in & st_q.scl_p & st_q.sda_p & ~sda_in;

  // clock fall driven by another master, used in slave operation
  assign scl_fall = st_q.scl_p & ~scl_in;

  // wait applies only to a two-wire format master
  assign wait_eff = st_q.mode[`IMR_MODE_WAIT] & st_q.mst & ~st_q.sync_fmt;

  // length from the programmed code and the format
  assign len_sel = frame_len(st_q.sync_fmt, st_q.mode[`IMR_MODE_BC_HI:`IMR_MODE_BC_LO]);

  // internal state held clear while the interface is off
  assign cnt_clr = ~st_q.en;

  // ======================================================================
  // next state
  always_comb begin
    st_d = st_q;
    acc = hsel & htrans[`IMR_HTRANS_ACT] & hready;
    irq_set = 1'b0;
    irq_clr = 1'b0;
    cnt_load = 1'b0;
    cnt_step = 1'b0;

    // constant response and open-drain value
    st_d.hresp = 1'b0;
    st_d.scl_o = 1'b0;
    st_d.sda_p = sda_in;
    st_d.scl_p = scl_in;

    // address phase: latch target, reads take one wait cycle
    st_d.wr_pend = acc & hwrite;
    st_d.rd_pend = acc & ~hwrite;
    st_d.hready = ~(acc & ~hwrite);
    if (acc) begin
      st_d.addr = haddr[`IMR_ADDR_MSB:`IMR_ADDR_LSB];
    end

    // read data phase: capture value after any earlier write landed
    if (st_q.rd_pend) begin
      st_d.hrdata = rd_val;
    end

    // frame progress: master steps on its own clock fall, slave on the line
    if (st_q.busy) begin
      if (st_q.mst) begin
        cnt_step = div_tick & ~st_q.scl_lo;
      end else begin
        cnt_step = scl_fall;
      end

      if (div_tick) begin
        st_d.scl_lo = ~st_q.scl_lo;
      end
    end

    // only ack left: either wait with clock low or run straight on
    if (cnt_last && wait_eff) begin
      st_d.wait_st = 1'b1;
      irq_set = 1'b1;
    end

    // frame end: flag, idle and counter field back to zero
    if (cnt_done) begin
      st_d.busy = 1'b0;
      irq_set = 1'b1;
      st_d.mode[`IMR_MODE_BC_HI:`IMR_MODE_BC_LO] = `IMR_BC_ZERO;
    end

    // cleared flag ends the wait, divider then releases the clock
    if (st_q.wait_st && !st_q.irq) begin
      st_d.wait_st = 1'b0;
    end

    // register writes
    if (st_q.wr_pend) begin
      if (hit(st_q.addr, `IMR_ADDR_MODE) && st_q.en) begin
        st_d.mode = hwdata[7:0];
      end else if (hit(st_q.addr, `IMR_ADDR_CTRL)) begin
        st_d.en = hwdata[`IMR_CTRL_EN];
        st_d.mst = hwdata[`IMR_CTRL_MST];
        st_d.sync_fmt = hwdata[`IMR_CTRL_SYNC];
        st_d.range = hwdata[`IMR_CTRL_RANGE];

        // go: start a frame if enabled and idle
        if (hwdata[`IMR_CTRL_GO] && hwdata[`IMR_CTRL_EN] && !st_q.busy) begin
          cnt_load = 1'b1;
          st_d.busy = 1'b1;
          st_d.scl_lo = hwdata[`IMR_CTRL_MST];
        end
      end else if (hit(st_q.addr, `IMR_ADDR_STAT)) begin
        irq_clr = ~hwdata[`IMR_STAT_IRQ];
      end
    end

    // start condition clears the counter field over any write
    if (start_det) begin
      st_d.mode[`IMR_MODE_BC_HI:`IMR_MODE_BC_LO] = `IMR_BC_ZERO;
    end

    // flag: a set in the clearing cycle wins
    st_d.irq = irq_set | (st_q.irq & ~irq_clr);

    // disabled interface: stop and drop transfer state
    if (!st_d.en) begin
      st_d.busy = 1'b0;
      st_d.wait_st = 1'b0;
      st_d.scl_lo = 1'b0;
      st_d.irq = 1'b0;
    end

    // slave never drives the clock line
    if (!st_d.mst) begin
      st_d.scl_lo = 1'b0;
    end
  end

  // ======================================================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.hready <= 1'b1;
      st_q.mode <= `IMR_MODE_RST;
      // lines seen idle high, so no false start after reset
      st_q.sda_p <= 1'b1;
      st_q.scl_p <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ======================================================================
  // outputs, all from flip-flops
  assign hreadyout = st_q.hready;
  assign hresp = st_q.hresp;
  assign hrdata = st_q.hrdata;

  // open-drain clock: value low, enable pulls
  assign scl_out = st_q.scl_o;
  assign scl_oe = st_q.scl_lo;

  // shifter takes order and alignment from this bit
  assign bit_order_lsb = st_q.mode[`IMR_MODE_ORDER];

endmodule // imr_mode_rate_bitcount

/* dv/imr_mrb_properties.sv */
/*
  port checks of the mode, rate and bit-count block, bound to its top.
  assumes one ahb-lite master whose hready is the block's hreadyout.
*/
`timescale 1ns/100ps

module imr_mrb_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // serial lines and shifter
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic bit_order_lsb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic wr_q, en_q, mst_q, go_q; // shadow of write phase and control bits
  logic [7:0] wa_q, hi_q; // write address, cycles scl_oe stayed high
  wire take_rd = hsel && htrans[1] && hready && !hwrite; // read address phase
  wire take_wr = hsel && htrans[1] && hready && hwrite; // write address phase
  wire mode_wr = wr_q && wa_q == 8'h00 && en_q; // honoured mode write
  wire ctrl_wr = wr_q && wa_q == 8'h04; // control write
  // =====================================================================
  // helper: shadows updated at the same edges as the block's registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      en_q <= 1'b0;
      mst_q <= 1'b0;
      go_q <= 1'b0;
      hi_q <= 8'h00;
    end else begin
      wr_q <= take_wr;
      if (take_wr) wa_q <= haddr[7:0];
      if (ctrl_wr) en_q <= hwdata[0];
      if (ctrl_wr) mst_q <= hwdata[1];
      go_q <= ctrl_wr && hwdata[0] && hwdata[1] && hwdata[4];
      hi_q <= !scl_oe ? 8'h00 : (hi_q == 8'hff ? hi_q : hi_q + 8'h01);
    end
  end
  // =====================================================================
  // bus and line checks
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_read_wait: assert property (take_rd |-> ##1 !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (take_wr |-> ##1 hreadyout ##1 hreadyout) else $error("write stalled");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(take_rd, 2)) else $error("read data moved");
  a_order_cause: assert property ($changed(bit_order_lsb) |-> $past(mode_wr))
    else $error("bit order changed without write");
  a_order_value: assert property ($past(mode_wr) |-> bit_order_lsb == $past(hwdata[7]))
    else $error("bit order not taken");
  a_drive_off: assert property (!(en_q && mst_q) && !$past(en_q && mst_q) && !$past(en_q && mst_q, 2)
    |-> !scl_oe && !scl_out) else $error("clock driven outside master");
  a_go_drive: assert property (go_q |-> ##[0:2] scl_oe) else $error("go did not pull clock");
  a_half_min: assert property ($fell(scl_oe) && en_q && mst_q && $past(en_q && mst_q)
    |-> hi_q >= 8'h0e) else $error("clock low phase too short");
endmodule // imr_mrb_properties

bind imr_mode_rate_bitcount imr_mrb_properties imr_mrb_properties_inst (.clk(clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl_in),
  .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .bit_order_lsb(bit_order_lsb));

/* dv/imr_bus_peer.sv */
/*
  far side of the two-wire bus: pull-ups, wired-and of both lines and a
  peer that makes start conditions and clock pulses.
  assumes tasks are called from the bench between clock edges.
*/
`timescale 1ns/100ps

module imr_bus_peer (
  // clock
  input wire logic clk,
  // block's open-drain clock
  input wire logic scl_oe,
  input wire logic scl_out,
  // resolved lines
  output logic scl_line,
  output logic sda_line
);
  logic scl_lo = 1'b0; // peer pulls the clock low
  logic sda_lo = 1'b0; // peer pulls the data low
  // open drain with pull-ups: any party pulling low wins
  assign scl_line = (scl_oe ? scl_out : 1'b1) & ~scl_lo;
  assign sda_line = ~sda_lo;
  // =====================================================================
  // start: data falls while the clock is high, clock then held low
  task automatic start_cond();
    scl_lo <= 1'b0;
    repeat (20) @(posedge clk);
    sda_lo <= 1'b1;
    repeat (20) @(posedge clk);
    scl_lo <= 1'b1;
    repeat (20) @(posedge clk);
    sda_lo <= 1'b0;
  endtask
  // clock pulses as a remote master, hl cycles per half, fast or slow
  task automatic clock_pulses(input int n, input int hl);
    repeat (n) begin
      scl_lo <= 1'b0;
      repeat (hl) @(posedge clk);
      scl_lo <= 1'b1;
      repeat (hl) @(posedge clk);
    end
  endtask
endmodule // imr_bus_peer

/* dv/test_imr_mode_rate_bitcount.sv */
/*
  self-checking bench of the mode, rate and bit-count block.
  assumes the peer model holds the far side of the serial lines.
*/
`timescale 1ns/100ps
`include "imr_cfg.svh"

module test_imr_mode_rate_bitcount;
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, scl_out, scl_oe, bit_order_lsb, scl_line, sda_line;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic oe_p = 1'b0; // scl_oe at the previous edge
  wire hready = hreadyout; // single slave drives the bus ready
  int err_count = 0;
  int num_checks = 0;
  int falls = 0; // clock falls made by the block
  logic [7:0] half0 [8] = '{8'h0e, 8'h14, 8'h18, 8'h20, 8'h28, 8'h32, 8'h38, 8'h40};

  imr_mode_rate_bitcount imr_mode_rate_bitcount_inst (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .bit_order_lsb(bit_order_lsb));
  imr_bus_peer imr_bus_peer_inst (.clk(clk), .scl_oe(scl_oe), .scl_out(scl_out), .scl_line(scl_line),
    .sda_line(sda_line));

  // =====================================================================
  // clock, fall monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    oe_p <= scl_oe;
    if (scl_oe === 1'b1 && oe_p === 1'b0) falls <= falls + 1;
  end
  initial begin
    #8000000;
    err_count++;
    end_sim();
  end

  // =====================================================================
  // compare, bus cycles, verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
  endtask
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
  endtask
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0;
    wait_rdy();
    d = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask
  task automatic poll_idle(output logic [31:0] st);
    do begin bus_rd(`IMR_ADDR_STAT, st); end while (st[1] === 1'b1 && st[2] !== 1'b1);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_regs();
    rd_chk(`IMR_ADDR_MODE, 32'h0);
    rd_chk(`IMR_ADDR_CTRL, 32'h0);
    rd_chk(`IMR_ADDR_STAT, 32'h0);
    chk({hresp, scl_out, scl_oe, bit_order_lsb}, 32'h0);
    bus_wr(`IMR_ADDR_MODE, 32'hff); // disabled, not honoured
    bus_wr(`IMR_ADDR_CTRL, 32'h5); // sync format keeps lsb first legal
    rd_chk(`IMR_ADDR_MODE, 32'h0);
    bus_wr(32'h0c, 32'hff);
    rd_chk(32'h0c, 32'h0);
  endtask
  task automatic t_order();
    bus_wr(`IMR_ADDR_MODE, 32'h80);
    @(posedge clk);
    chk(bit_order_lsb, 32'h1);
    rd_chk(`IMR_ADDR_MODE, 32'h80);
    bus_wr(`IMR_ADDR_CTRL, 32'h0);
    rd_chk(`IMR_ADDR_MODE, 32'h0);
    bus_wr(`IMR_ADDR_MODE, 32'h0);
    bus_wr(`IMR_ADDR_CTRL, 32'h5);
    rd_chk(`IMR_ADDR_MODE, 32'h80);
    bus_wr(`IMR_ADDR_MODE, 32'h0);
    @(posedge clk);
    chk(bit_order_lsb, 32'h0);
  endtask
  task automatic t_slave();
    logic [31:0] st;
    bus_wr(`IMR_ADDR_CTRL, 32'h1);
    imr_bus_peer_inst.start_cond();
    bus_wr(`IMR_ADDR_MODE, 32'h05); // nonzero count only with clock low
    imr_bus_peer_inst.start_cond();
    rd_chk(`IMR_ADDR_MODE, 32'h0);
    bus_wr(`IMR_ADDR_MODE, 32'h42);
    bus_wr(`IMR_ADDR_CTRL, 32'h11);
    imr_bus_peer_inst.clock_pulses(2, 25);
    imr_bus_peer_inst.clock_pulses(1, 90);
    poll_idle(st);
    chk(st[2:1], 32'h0);
    rd_chk(`IMR_ADDR_MODE, 32'h40);
    chk(scl_oe, 32'h0);
  endtask
  task automatic t_rates();
    int n;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        bus_wr(`IMR_ADDR_CTRL, 32'(3 + 8 * r));
        bus_wr(`IMR_ADDR_MODE, 32'(c * 8));
        bus_wr(`IMR_ADDR_CTRL, 32'(19 + 8 * r));
        n = 0;
        while (scl_oe !== 1'b1 && n < 10) begin @(posedge clk); n++; end
        n = 0;
        do begin @(posedge clk); n++; end while (scl_oe === 1'b1 && n < 300);
        n = 0;
        do begin @(posedge clk); n++; end while (scl_oe === 1'b0 && n < 300);
        chk(32'(n), 32'(half0[c]) << r);
        bus_wr(`IMR_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(scl_oe, 32'h0);
      end
    end
    rd_chk(`IMR_ADDR_STAT, 32'h0);
  endtask
  task automatic run_frame(input logic [31:0] ctl, input logic [31:0] md, input int nf, input logic wt);
    logic [31:0] st;
    int f0;
    bus_wr(`IMR_ADDR_CTRL, ctl);
    bus_wr(`IMR_ADDR_MODE, md); // between frames only
    f0 = falls;
    bus_wr(`IMR_ADDR_CTRL, ctl | 32'h10);
    poll_idle(st);
    if (wt) begin
      chk(32'(falls - f0), 32'h9);
      chk(st[2:0], 32'h7);
      repeat (40) @(posedge clk);
      chk({scl_oe, 8'(falls - f0)}, 32'h109);
      bus_wr(`IMR_ADDR_STAT, 32'h0);
      poll_idle(st);
    end
    chk(32'(falls - f0), 32'(nf + 1));
    chk(st[2:0], 32'h1);
    rd_chk(`IMR_ADDR_MODE, md & 32'hf8);
    bus_wr(`IMR_ADDR_CTRL, 32'h0);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; rstn = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_order();
    t_slave();
    t_rates();
    run_frame(32'h3, 32'h03, 4, 1'b0);
    run_frame(32'h3, 32'h00, 9, 1'b0);
    run_frame(32'h3, 32'h07, 8, 1'b0);
    run_frame(32'h7, 32'h00, 8, 1'b0);
    run_frame(32'h7, 32'h01, 1, 1'b0);
    run_frame(32'h7, 32'h07, 7, 1'b0);
    run_frame(32'h3, 32'h40, 9, 1'b1);
    run_frame(32'h7, 32'h40, 8, 1'b0);
    end_sim();
  end
endmodule // test_imr_mode_rate_bitcount
